//--- shared/rafc_defs.svh
// constants of the receive automatic flow controller
//------------------------------------------------------------
// Overview of operation
// - no pause or jam while transmitter off
// - high threshold bits 23:16, 64-byte units
// - one pause frame at high, MAC time
// - half duplex: jam selected frames for duration
// - low threshold bits 15:8 sends zero pause
// - zero pause only after real pause sent
// - zero pause active when any select set
// - duration code bits 7:4, unused full duplex
// - duration table, 10M adds 2.2 us
// - multicast select bit 3 jams multicasts
// - broadcast select bit 2 jams broadcasts
// - own-address select bit 1 jams own frames
// - select bits 3:1 in full duplex only enable the zero pause
// - any-frame bit 0, sole full duplex pause enable
// - any-frame half duplex acts at preamble
// - any-frame full duplex requests pause immediately
// - any-frame bit overrides bits 3:1
//------------------------------------------------------------
`ifndef RAFC_DEFS_SVH
`define RAFC_DEFS_SVH
`define RAFC_CFG_ADDR     8'hAC
`define RAFC_STAT_ADDR    8'hB4
`define RAFC_HI_MSB       23
`define RAFC_HI_LSB       16
`define RAFC_LO_MSB       15
`define RAFC_LO_LSB       8
`define RAFC_DUR_MSB      7
`define RAFC_DUR_LSB      4
`define RAFC_SEL_MSB      3
`define RAFC_SEL_LSB      0
`define RAFC_SEL_MC       3
`define RAFC_SEL_BC       2
`define RAFC_SEL_OWN      1
`define RAFC_SEL_ANY      0
`define RAFC_UNIT_SHIFT   6'h06
`define RAFC_CFG_RESET    24'h00_0000
`define RAFC_CLK_MHZ      250
`define RAFC_TICK_NS      100
`define RAFC_BP_SHORT_TK  13'h0032
`define RAFC_BP_MID_TK    13'h00FA
`define RAFC_BP_LONG_TK   13'h01F4
`define RAFC_BP_10M_TK    13'h0016
`define RAFC_SHORT_CODES  4'h3
`endif

//--- shared/rafc_pkg.sv
// types of the receive automatic flow controller
`default_nettype none
package rafc_pkg;
    typedef struct packed {
        logic [7:0] fifo_high_threshold;
        logic [7:0] fifo_low_threshold;
        logic [3:0] jam_duration_code;
        logic [3:0] select_bits;
    } rafc_cfg_type;

    typedef struct packed {
        logic frame_start;
        logic addr_valid;
        logic is_multicast;
        logic is_broadcast;
        logic is_own;
    } rafc_rx_type;

    typedef enum logic [3:0] {
        FC_IDLE   = 4'h1,
        FC_PAUSE  = 4'h2,
        FC_HELD   = 4'h4,
        FC_RESUME = 4'h8
    } rafc_fc_state_type;
endpackage : rafc_pkg
`default_nettype wire

//--- rtl/rafc_top.sv
// receive automatic flow controller with apb configuration
`include "rafc_defs.svh"
`default_nettype none
module rafc_top
    import rafc_pkg::*;
#(
    parameter int FIFO_BW     = 14,
    parameter int TICK_CYCLES = `RAFC_TICK_NS * `RAFC_CLK_MHZ / 1000
) (
    input  wire logic               mclk,           // mac clock
    input  wire logic               rst,            // async reset
    input  wire logic               psel,           // apb select
    input  wire logic               penable,        // apb enable
    input  wire logic               pwrite,         // apb direction
    input  wire logic [7:0]         paddr,          // apb byte address
    input  wire logic [31:0]        pwdata,         // apb write data
    output logic                    pready,         // apb ready
    output logic [31:0]             prdata,         // apb read data
    output logic                    pslverr,        // apb error
    input  wire logic               tx_enable,      // mac transmitter on
    input  wire logic               full_duplex,    // duplex mode
    input  wire logic               speed_10,       // 10 mbit link
    input  wire logic [FIFO_BW-1:0] rx_fifo_bytes,  // rx fifo level
    input  wire rafc_rx_type        rx_event,       // rx frame events
    input  wire logic [15:0]        pause_time_value, // mac pause time
    output logic                    pause_req,      // pause request
    input  wire logic               pause_ack,      // pause frame sent
    output logic [15:0]             pause_time,     // time to send
    output logic                    jam             // back pressure
);
    //--------------------------------------------------------
    // registers
    //--------------------------------------------------------
    rafc_cfg_type      cfg;
    rafc_fc_state_type state;
    rafc_fc_state_type next_state;
    logic [12:0]       jam_cnt;
    logic [15:0]       tick_cnt;
    logic              tick_en;

    //--------------------------------------------------------
    // duration table in 100 ns ticks
    //--------------------------------------------------------
    function automatic logic [12:0] dur_ticks(
        input logic [3:0] code,
        input logic       ten
    );
        logic [12:0] base;
        base = 13'h0000;
        if (code < `RAFC_SHORT_CODES) begin
            base = 13'(({9'h000, code} + 13'h0001) * `RAFC_BP_SHORT_TK);
        end else if (code == `RAFC_SHORT_CODES) begin
            base = `RAFC_BP_MID_TK;
        end else begin
            base = 13'(({9'h000, code} - 13'h0003) * `RAFC_BP_LONG_TK);
        end
        // 10 mbit entries run longer by a fixed amount
        dur_ticks = ten ? 13'(base + `RAFC_BP_10M_TK) : base;
    endfunction : dur_ticks

    //--------------------------------------------------------
    // apb decode
    //--------------------------------------------------------
    wire         setup    = psel && !penable;
    wire         access   = psel && penable;
    wire         hit_cfg  = (paddr == `RAFC_CFG_ADDR);
    wire         hit_stat = (paddr == `RAFC_STAT_ADDR);
    wire         mapped   = hit_cfg || hit_stat;
    wire         cfg_wr   = access && pwrite && hit_cfg;
    wire [31:0]  cfg_word = {8'h00, cfg.fifo_high_threshold,
                             cfg.fifo_low_threshold,
                             cfg.jam_duration_code, cfg.select_bits};
    wire [31:0]  stat_word;
    wire [31:0]  rd_word  = hit_cfg  ? cfg_word :
                            hit_stat ? stat_word : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg <= `RAFC_CFG_RESET;
        end else if (cfg_wr) begin
            cfg.fifo_high_threshold <= pwdata[`RAFC_HI_MSB:`RAFC_HI_LSB];
            cfg.fifo_low_threshold  <= pwdata[`RAFC_LO_MSB:`RAFC_LO_LSB];
            cfg.jam_duration_code   <= pwdata[`RAFC_DUR_MSB:`RAFC_DUR_LSB];
            cfg.select_bits         <= pwdata[`RAFC_SEL_MSB:`RAFC_SEL_LSB];
        end
    end

    //--------------------------------------------------------
    // threshold compare
    //--------------------------------------------------------
    wire [FIFO_BW-1:0] hi_bytes =
        FIFO_BW'({6'h00, cfg.fifo_high_threshold} << `RAFC_UNIT_SHIFT);
    wire [FIFO_BW-1:0] lo_bytes =
        FIFO_BW'({6'h00, cfg.fifo_low_threshold} << `RAFC_UNIT_SHIFT);
    wire at_high   = rx_fifo_bytes >= hi_bytes;
    wire below_low = rx_fifo_bytes <  lo_bytes;

    wire sel_any = cfg.select_bits[`RAFC_SEL_ANY];
    wire afc_on  = |cfg.select_bits;

    //--------------------------------------------------------
    // full duplex pause sequencing
    //--------------------------------------------------------
    wire fd_go   = tx_enable && full_duplex;
    wire start_p = fd_go && sel_any && at_high;
    wire start_r = fd_go && afc_on && below_low;
    wire sent    = pause_req && pause_ack;

    always_comb begin
        next_state = state;
        unique case (state)
            FC_IDLE: begin
                if (start_p) begin
                    next_state = FC_PAUSE;
                end
            end
            FC_PAUSE: begin
                if (sent) begin
                    next_state = FC_HELD;
                end else if (!start_p) begin
                    next_state = FC_IDLE;
                end
            end
            FC_HELD: begin
                if (start_r) begin
                    next_state = FC_RESUME;
                end
            end
            FC_RESUME: begin
                if (sent) begin
                    next_state = FC_IDLE;
                end else if (!start_r) begin
                    next_state = FC_HELD;
                end
            end
            default: begin
                next_state = FC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= FC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // pause time latched as the request opens
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pause_time <= 16'h0000;
        end else if (state == FC_IDLE && next_state == FC_PAUSE) begin
            pause_time <= pause_time_value;
        end else if (next_state == FC_RESUME) begin
            pause_time <= 16'h0000;
        end
    end

    // request held until the mac reports the frame sent, or dropped once its start condition goes away
    assign pause_req = tx_enable && full_duplex &&
                       (state == FC_PAUSE || state == FC_RESUME);

    //--------------------------------------------------------
    // half duplex back pressure
    //--------------------------------------------------------
    wire hd_go    = tx_enable && !full_duplex && at_high;
    wire addr_hit =
        (rx_event.is_multicast && cfg.select_bits[`RAFC_SEL_MC])  ||
        (rx_event.is_broadcast && cfg.select_bits[`RAFC_SEL_BC])  ||
        (rx_event.is_own       && cfg.select_bits[`RAFC_SEL_OWN]);
    wire any_trig = sel_any && rx_event.frame_start;
    wire sel_trig = !sel_any && rx_event.addr_valid && addr_hit;
    wire jam_go   = hd_go && (any_trig || sel_trig);
    wire jam_act  = (jam_cnt != 13'h0000);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt <= 16'h0000;
        end else if (tick_en || jam_go) begin
            tick_cnt <= 16'h0000;
        end else begin
            tick_cnt <= tick_cnt + 16'h0001;
        end
    end
    assign tick_en = (tick_cnt == 16'(TICK_CYCLES - 1));

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            jam_cnt <= 13'h0000;
        end else if (!tx_enable || full_duplex) begin
            jam_cnt <= 13'h0000;
        end else if (jam_go && !jam_act) begin
            jam_cnt <= dur_ticks(cfg.jam_duration_code, speed_10);
        end else if (jam_act && tick_en) begin
            jam_cnt <= jam_cnt - 13'h0001;
        end
    end

    assign jam = jam_act && tx_enable && !full_duplex;

    //--------------------------------------------------------
    // status word
    //--------------------------------------------------------
    assign stat_word = {2'b00, 14'(rx_fifo_bytes), 13'h0000, at_high, jam_act,
                        (state == FC_HELD || state == FC_RESUME)};

    //--------------------------------------------------------
    // checks
    //--------------------------------------------------------
    sequence s_pause_sent;
        pause_req && pause_ack;
    endsequence

    sequence s_pause_open;
        state == FC_IDLE && start_p;
    endsequence

    txoff_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        !tx_enable |-> !pause_req && !jam)
        else $error("flow control active with transmitter off");

    high_trigger_a: assert property (@(posedge mclk) disable iff (rst)
        s_pause_open |=> state == FC_PAUSE && pause_req)
        else $error("high level did not open a pause request");

    pause_value_a: assert property (@(posedge mclk) disable iff (rst)
        s_pause_open |=> pause_time == $past(pause_time_value))
        else $error("pause time not taken from mac value");

    zero_resume_a: assert property (@(posedge mclk) disable iff (rst)
        state == FC_RESUME |-> pause_time == 16'h0000)
        else $error("resume frame carries nonzero time");

    resume_after_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(state == FC_RESUME) |-> $past(state == FC_HELD))
        else $error("zero pause without earlier pause");

    held_on_ack_a: assert property (@(posedge mclk) disable iff (rst)
        state == FC_PAUSE ##0 s_pause_sent |=> state == FC_HELD)
        else $error("sent pause did not set paused flag");

    fd_no_jam_a: assert property (@(posedge mclk) disable iff (rst)
        full_duplex |-> !jam)
        else $error("back pressure in full duplex");

    jam_load_a: assert property (@(posedge mclk) disable iff (rst)
        jam_go && !jam_act && tx_enable && !full_duplex
        |=> jam_cnt == dur_ticks($past(cfg.jam_duration_code),
                                 $past(speed_10)) && jam)
        else $error("jam duration not loaded from table");

    any_wins_a: assert property (@(posedge mclk) disable iff (rst)
        sel_any && rx_event.addr_valid && !rx_event.frame_start
        && !jam_act |=> !jam_act)
        else $error("address match used while any-frame set");

    preamble_jam_a: assert property (@(posedge mclk) disable iff (rst)
        hd_go && sel_any && rx_event.frame_start && !jam_act
        && cfg.jam_duration_code != 4'h0 |=> jam)
        else $error("any-frame jam missed at preamble");

endmodule : rafc_top
`default_nettype wire

//--- dv/rafc_mac_model.sv
// mac transmitter model that answers pause requests
`default_nettype none
module rafc_mac_model (
    input  wire logic        mclk,       // clock
    input  wire logic        rst,        // reset
    input  wire logic        slow,       // late answer
    input  wire logic        pause_req,  // request
    input  wire logic [15:0] pause_time, // time to send
    output logic             pause_ack,  // frame sent
    output logic [7:0]       sent,       // frames sent
    output logic [15:0]      last_time   // time of last frame
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;

    // frame waits for the next free transmit window
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pause_ack <= 1'b0;
            wait_cnt <= 4'h0;
            sent <= 8'h00;
            last_time <= 16'h0000;
        end else if (pause_ack) begin
            pause_ack <= 1'b0;
            wait_cnt <= 4'h0;
        end else if (pause_req) begin
            if (wait_cnt >= (slow ? 4'h6 : 4'h1)) begin
                pause_ack <= 1'b1;
                sent <= sent + 8'h01;
                last_time <= pause_time;
            end else begin
                wait_cnt <= wait_cnt + 4'h1;
            end
        end else begin
            wait_cnt <= 4'h0;
        end
    end
endmodule : rafc_mac_model
`default_nettype wire

//--- dv/rafc_top_bench.sv
// self-checking bench of the receive automatic flow controller
`default_nettype none
module rafc_top_bench import rafc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic tx_enable = 1, full_duplex = 1, speed_10 = 0, slow = 0;
    logic pready, pslverr, pause_req, pause_ack, jam, err, x;
    logic [7:0] paddr = '0, sent, hi, lo;
    logic [31:0] pwdata = '0, prdata, rd, v;
    logic [13:0] fifo = '0;
    logic [15:0] ptv = '0, pause_time, last_time, t;
    logic [3:0] sel, code;
    rafc_rx_type ev = '0, e;
    int num_errors = 0, checks = 0, i, k, m;

    always #2 mclk = ~mclk;

    rafc_top #(.FIFO_BW(14), .TICK_CYCLES(1)) i_rafc_top (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .tx_enable(tx_enable), .full_duplex(full_duplex),
        .speed_10(speed_10), .rx_fifo_bytes(fifo), .rx_event(ev),
        .pause_time_value(ptv), .pause_req(pause_req), .pause_ack(pause_ack),
        .pause_time(pause_time), .jam(jam));

    rafc_mac_model i_rafc_mac_model (.mclk(mclk), .rst(rst), .slow(slow),
        .pause_req(pause_req), .pause_time(pause_time), .pause_ack(pause_ack),
        .sent(sent), .last_time(last_time));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        if (n >= 20) begin
            num_errors++;
            print_verdict();
        end
    endtask : apb

    // duration in ticks: 5,10,15,25 us then 50 us steps, 10 mbit adds 2.2 us
    function automatic int ticks(logic [3:0] c, logic ten);
        int r;
        r = (c < 4) ? ((c == 3) ? 250 : 50 * (c + 1)) : (c - 3) * 500;
        return r + (ten ? 22 : 0);
    endfunction : ticks

    task automatic settle(logic [13:0] f, logic [7:0] n, logic [15:0] tm);
        fifo <= f;
        repeat (30) @(posedge mclk);
        check("pause_count", sent, n);
        check("pause_time", last_time, tm);
    endtask : settle

    // jam is looked at on the falling edge, where it has settled
    task automatic pulse(rafc_rx_type pe, logic exp);
        ev <= pe;
        @(posedge mclk);
        ev <= '0;
        @(negedge mclk);
        check("jam", jam, exp);
        @(posedge mclk);
    endtask : pulse

    // the falling edge inside pulse already saw the first jam cycle
    task automatic jam_len(int tk);
        int n;
        n = 1;
        @(negedge mclk);
        while (jam === 1'b1 && n < 7000) begin
            n++;
            @(negedge mclk);
        end
        @(posedge mclk);
        if (n >= 7000) begin
            num_errors++;
            print_verdict();
        end
        check("jam_len", n >= tk - 2 && n <= tk + 2, 1);
    endtask : jam_len

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(79));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(0, 8'hAC, 32'h0);
        check("cfg_reset", rd, 32'h0);
        // any-frame bit kept clear so a zero high level cannot start a pause
        v = $urandom & 32'hFFFF_FFFE;
        apb(1, 8'hAC, v);
        apb(0, 8'hAC, 32'h0);
        check("cfg", rd, {8'h00, v[23:0]});
        apb(1, 8'h10, v);
        apb(0, 8'h10, 32'h0);
        check("unmapped_data", rd, 32'h0);
        check("unmapped_err", err, 1);
        // full duplex pause and resume, prompt then slow partner
        t = 16'h0000;
        for (i = 0; i < 2; i++) begin
            hi = 8'($urandom_range(4, 63));
            lo = 8'($urandom_range(1, hi - 1));
            v = $urandom;
            slow <= i[0];
            apb(1, 8'hAC, {8'h00, hi, lo, v[3:0], v[7:5], 1'b1});
            settle({hi, 6'h00} - 14'h1, 8'(2 * i), t);
            t = 16'($urandom_range(1, 16'hFFFF));
            ptv <= t;
            settle({hi, 6'h00}, 8'(2 * i + 1), t);
            settle({lo, 6'h00}, 8'(2 * i + 1), t);
            apb(0, 8'hB4, 32'h0);
            check("status", rd, {2'b00, lo, 6'h00, 16'h0001});
            check("status_err", err, 0);
            t = 16'h0000;
            settle({lo, 6'h00} - 14'h1, 8'(2 * i + 2), t);
        end
        // full duplex without the any-frame bit stays quiet
        apb(1, 8'hAC, 32'h0002_01FE);
        settle(14'h3FFF, 8'h04, t);
        pulse(5'b01111, 1'b0);
        // transmitter off blocks pause and jam
        fifo <= 14'h0;
        tx_enable <= 1'b0;
        apb(1, 8'hAC, 32'h0002_011F);
        settle(14'h3FFF, 8'h04, t);
        full_duplex <= 1'b0;
        pulse(5'b10000, 1'b0);
        pulse(5'b01111, 1'b0);
        fifo <= 14'h0;
        @(posedge mclk);
        tx_enable <= 1'b1;
        // half duplex selection table with random durations
        for (k = 0; k < 4; k++) begin
            for (m = 0; m < 4; m++) begin
                v = $urandom;
                code = v[3:0];
                sel = (k == 0) ? {v[6:4], 1'b1} : 4'(1 << k);
                e = (m == 0) ? 5'b10000 : (5'b01000 | (5'b00100 >> (m - 1)));
                x = (k == 0) ? (m == 0) : (m == 4 - k);
                apb(1, 8'hAC, {16'h0008, 8'h01, code, sel});
                fifo <= 14'h01FF;
                speed_10 <= v[8];
                pulse(e, 1'b0);
                fifo <= 14'h0200 + 14'($urandom_range(0, 1000));
                pulse(e, x);
                if (x) begin
                    jam_len(ticks(code, v[8]));
                end
            end
        end
        print_verdict();
    end
endmodule : rafc_top_bench
`default_nettype wire
